// file: ssc_core.sv
// serial interface status flags, transfer counter, enables and wire-mode pin control
`timescale 1ns/1ps
module ssc_core (
   // clock, reset and clock enable
   input  wire logic       i_clk,
   input  wire logic       i_rst_b,
   input  wire logic       i_ce,
   // register port
   input  wire logic [1:0] i_addr,
   input  wire logic [7:0] i_wdata,
   input  wire logic       i_wr,
   input  wire logic       i_rd,
   output logic      [7:0] o_rdata,
   // processor side
   input  wire logic       i_global_ie,
   input  wire logic       i_timer0_ovf,
   output logic            o_irq_start,
   output logic            o_irq_wrap,
   output logic            o_wake_idle,
   output logic            o_wake_all,
   // port latch and direction bits
   input  wire logic       i_port_do,
   input  wire logic       i_ddr_do,
   input  wire logic       i_port_sda,
   input  wire logic       i_ddr_sda,
   input  wire logic       i_port_scl,
   input  wire logic       i_ddr_scl,
   output logic            o_scl_toggle,
   // pins
   input  wire logic       i_sda_pin,
   input  wire logic       i_scl_pin,
   output logic            o_do_override,
   output logic            o_do_out,
   output logic            o_do_oe,
   output logic            o_do_pullup,
   output logic            o_two_wire,
   output logic            o_pullup_dis,
   output logic            o_sda_out,
   output logic            o_sda_oe,
   output logic            o_scl_out,
   output logic            o_scl_oe
);
   logic [1:0] pins_s;
   logic       sda_s;
   logic       scl_s;
   logic       sda_d;
   logic       scl_d;

   ssc_sync #(
      .WIDTH (2)
   ) u_sync (
      .i_clk   (i_clk),
      .i_rst_b (i_rst_b),
      .i_ce    (i_ce),
      .i_async ({i_sda_pin, i_scl_pin}),
      .o_sync  (pins_s)
   );

   assign sda_s = pins_s[1];
   assign scl_s = pins_s[0];

   // register state
   logic [7:0] shift;
   logic [3:0] count;
   logic       start_flag;
   logic       wrap_flag;
   logic       stop_flag;
   logic       start_hold;
   logic       do_latch;
   logic       sie;
   logic       oie;
   logic [1:0] wm;
   logic [1:0] cs;
   logic       clk_sel;
   logic       toggle;
   logic [7:0] rdata;

   logic [7:0] next_shift;
   logic [3:0] next_count;
   logic       next_start_flag;
   logic       next_wrap_flag;
   logic       next_stop_flag;
   logic       next_start_hold;
   logic       next_do_latch;
   logic       next_sie;
   logic       next_oie;
   logic [1:0] next_wm;
   logic [1:0] next_cs;
   logic       next_clk_sel;
   logic       next_toggle;
   logic [7:0] next_rdata;

   // decoded events
   logic       wr_st;
   logic       wr_ct;
   logic       wr_sh;
   logic       scl_rise;
   logic       scl_fall;
   logic       sda_rise;
   logic       sda_fall;
   logic       is_two;
   logic       ext;
   logic       soft_strobe;
   logic       tc_strobe;
   logic       shift_clk;
   logic       count_clk;
   logic       latch_clk;
   logic       start_cond;
   logic       stop_cond;
   logic       ext_edge_start;
   logic       wrap_evt;
   logic       coll;

   function automatic logic two_wire_mode(input logic [1:0] mode);
      two_wire_mode = (mode == ssc_pkg::WM_TWO) || (mode == ssc_pkg::WM_TWO_HOLD);
   endfunction

   always_comb
   begin
      wr_st       = i_wr && (i_addr == ssc_pkg::ADDR_STATUS);
      wr_ct       = i_wr && (i_addr == ssc_pkg::ADDR_CONTROL);
      wr_sh       = i_wr && (i_addr == ssc_pkg::ADDR_SHIFT);
      scl_rise    = scl_s && !scl_d;
      scl_fall    = !scl_s && scl_d;
      sda_rise    = sda_s && !sda_d;
      sda_fall    = !sda_s && sda_d;
      is_two      = two_wire_mode(wm);
      ext         = cs[1];
      soft_strobe = wr_ct && i_wdata[ssc_pkg::CT_CLK] && (cs == ssc_pkg::CS_SOFT);
      tc_strobe   = wr_ct && i_wdata[ssc_pkg::CT_TC];
      // shift register clock per source select
      case (cs)
         ssc_pkg::CS_SOFT:    shift_clk = soft_strobe;
         ssc_pkg::CS_TIMER:   shift_clk = i_timer0_ovf;
         ssc_pkg::CS_EXT_POS: shift_clk = scl_rise;
         ssc_pkg::CS_EXT_NEG: shift_clk = scl_fall;
         default:             shift_clk = 1'b0;
      endcase
      // counter clock: external sources count both edges unless strobe-select is set
      if (ext)
      begin
         count_clk = clk_sel ? tc_strobe : (scl_rise || scl_fall);
      end
      else
      begin
         count_clk = shift_clk;
      end
      // output latch follows the edge opposite to the sampling edge
      latch_clk = (cs == ssc_pkg::CS_EXT_POS) ? scl_fall : scl_rise;
      // start and stop detectors only run in two-wire modes
      start_cond = is_two && scl_s && scl_d && sda_fall;
      stop_cond  = is_two && scl_s && scl_d && sda_rise;
      ext_edge_start = !is_two && ext && !clk_sel && (scl_rise || scl_fall);
      wrap_evt = count_clk && (count == ssc_pkg::COUNT_MAX);
      coll     = shift[7] != sda_s;
   end

   always_comb
   begin
      next_shift      = shift;
      next_count      = count;
      next_start_flag = start_flag;
      next_wrap_flag  = wrap_flag;
      next_stop_flag  = stop_flag;
      next_start_hold = start_hold;
      next_do_latch   = do_latch;
      next_sie        = sie;
      next_oie        = oie;
      next_wm         = wm;
      next_cs         = cs;
      next_clk_sel    = clk_sel;
      next_toggle     = 1'b0;
      next_rdata      = 8'h00;

      if (i_ce)
      begin
         // a register write wins over a serial clock in the same cycle
         if (wr_sh)
         begin
            next_shift = i_wdata;
         end
         else if (shift_clk)
         begin
            next_shift = {shift[6:0], sda_s};
         end

         if (wr_st)
         begin
            next_count = i_wdata[ssc_pkg::ST_CNT_MSB:0];
         end
         else if (count_clk)
         begin
            next_count = count + 4'h1;
         end

         if (latch_clk)
         begin
            next_do_latch = next_shift[7];
         end

         // flags: a written one clears, a written zero keeps, a new start or stop event wins, a wrap during any status write is lost
         if (wr_st && i_wdata[ssc_pkg::ST_START])
         begin
            next_start_flag = 1'b0;
            next_start_hold = 1'b0;
         end
         if (wr_st && i_wdata[ssc_pkg::ST_WRAP])
         begin
            next_wrap_flag = 1'b0;
         end
         if (wr_st && i_wdata[ssc_pkg::ST_STOP])
         begin
            next_stop_flag = 1'b0;
         end
         if (start_cond || ext_edge_start)
         begin
            next_start_flag = 1'b1;
         end
         // hold begins once the master has pulled the clock low after a start
         if (start_flag && is_two && scl_fall && !(wr_st && i_wdata[ssc_pkg::ST_START]))
         begin
            next_start_hold = 1'b1;
         end
         if (!is_two)
         begin
            next_start_hold = 1'b0;
         end
         if (wrap_evt && !wr_st)
         begin
            next_wrap_flag = 1'b1;
         end
         if (stop_cond)
         begin
            next_stop_flag = 1'b1;
         end

         if (wr_ct)
         begin
            next_sie     = i_wdata[ssc_pkg::CT_SIE];
            next_oie     = i_wdata[ssc_pkg::CT_OIE];
            next_wm      = i_wdata[ssc_pkg::CT_WM_LSB+1:ssc_pkg::CT_WM_LSB];
            next_cs      = i_wdata[ssc_pkg::CT_CS_LSB+1:ssc_pkg::CT_CS_LSB];
            next_clk_sel = i_wdata[ssc_pkg::CT_CLK];
            next_toggle  = i_wdata[ssc_pkg::CT_TC];
         end

         if (i_rd)
         begin
            case (i_addr)
               ssc_pkg::ADDR_STATUS:  next_rdata = {start_flag, wrap_flag, stop_flag, coll, count};
               ssc_pkg::ADDR_CONTROL: next_rdata = {sie, oie, wm, cs, 2'b00};
               ssc_pkg::ADDR_SHIFT:   next_rdata = shift;
               default:               next_rdata = 8'h00;
            endcase
         end
      end
      else
      begin
         next_rdata  = rdata;
         next_toggle = toggle;
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         shift      <= ssc_pkg::RST_SHIFT;
         count      <= ssc_pkg::RST_COUNT;
         start_flag <= 1'b0;
         wrap_flag  <= 1'b0;
         stop_flag  <= 1'b0;
         start_hold <= 1'b0;
         do_latch   <= 1'b0;
         sie        <= 1'b0;
         oie        <= 1'b0;
         wm         <= ssc_pkg::RST_WM;
         cs         <= ssc_pkg::RST_CS;
         clk_sel    <= 1'b0;
         toggle     <= 1'b0;
         rdata      <= 8'h00;
         sda_d      <= 1'b1;
         scl_d      <= 1'b1;
      end
      else
      begin
         shift      <= next_shift;
         count      <= next_count;
         start_flag <= next_start_flag;
         wrap_flag  <= next_wrap_flag;
         stop_flag  <= next_stop_flag;
         start_hold <= next_start_hold;
         do_latch   <= next_do_latch;
         sie        <= next_sie;
         oie        <= next_oie;
         wm         <= next_wm;
         cs         <= next_cs;
         clk_sel    <= next_clk_sel;
         toggle     <= next_toggle;
         rdata      <= next_rdata;
         if (i_ce)
         begin
            sda_d <= sda_s;
            scl_d <= scl_s;
         end
      end
   end

   // pin and request outputs
   logic do_bit;
   logic wrap_hold;

   always_comb
   begin
      // internal sources leave the latch transparent
      do_bit    = ext ? do_latch : shift[7];
      wrap_hold = (wm == ssc_pkg::WM_TWO_HOLD) && wrap_flag;
      o_rdata      = rdata;
      o_scl_toggle = toggle;
      o_irq_start  = start_flag && sie && i_global_ie;
      o_irq_wrap   = wrap_flag && oie && i_global_ie;
      o_wake_idle  = o_irq_wrap || o_irq_start;
      o_wake_all   = o_irq_start;
      o_two_wire   = is_two;
      o_pullup_dis = is_two;
      // three-wire data output replaces the port latch, direction kept
      o_do_override = (wm == ssc_pkg::WM_THREE);
      o_do_out      = o_do_override && do_bit;
      o_do_oe       = o_do_override && i_ddr_do;
      o_do_pullup   = o_do_override && !i_ddr_do && i_port_do;
      // open-collector: output value is always low, only the enable moves
      o_sda_out = 1'b0;
      o_scl_out = 1'b0;
      o_sda_oe  = is_two && i_ddr_sda && (!do_bit || !i_port_sda);
      o_scl_oe  = is_two && i_ddr_scl
                  && (!i_port_scl || start_hold || wrap_hold);
   end
endmodule

// file: ssc_pkg.sv
// constants for the serial interface status and control block
package ssc_pkg;
   // register index on the 2-bit register port
   localparam logic [1:0] ADDR_STATUS  = 2'h0;
   localparam logic [1:0] ADDR_CONTROL = 2'h1;
   localparam logic [1:0] ADDR_SHIFT   = 2'h2;
   // serial_status fields
   localparam int ST_START   = 7;
   localparam int ST_WRAP    = 6;
   localparam int ST_STOP    = 5;
   localparam int ST_COLL    = 4;
   localparam int ST_CNT_MSB = 3;
   // serial_control fields
   localparam int CT_SIE     = 7;
   localparam int CT_OIE     = 6;
   localparam int CT_WM_LSB  = 4;
   localparam int CT_CS_LSB  = 2;
   localparam int CT_CLK     = 1;
   localparam int CT_TC      = 0;
   // values after reset, and the counter value at which it wraps
   localparam logic [7:0] RST_SHIFT   = 8'h00;
   localparam logic [3:0] RST_COUNT   = 4'h0;
   localparam logic [1:0] RST_WM      = 2'h0;
   localparam logic [1:0] RST_CS      = 2'h0;
   localparam logic [3:0] COUNT_MAX   = 4'hf;
   // wire mode field encodings
   localparam logic [1:0] WM_OFF      = 2'h0;
   localparam logic [1:0] WM_THREE    = 2'h1;
   localparam logic [1:0] WM_TWO      = 2'h2;
   localparam logic [1:0] WM_TWO_HOLD = 2'h3;
   // clock source select encodings
   localparam logic [1:0] CS_SOFT     = 2'h0;
   localparam logic [1:0] CS_TIMER    = 2'h1;
   localparam logic [1:0] CS_EXT_POS  = 2'h2;
   localparam logic [1:0] CS_EXT_NEG  = 2'h3;
endpackage

// file: ssc_sync.sv
// two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
module ssc_sync #(
   parameter int WIDTH = 2
) (
   // clock and reset
   input  wire logic             i_clk,
   input  wire logic             i_rst_b,
   input  wire logic             i_ce,
   // asynchronous levels in, synchronised levels out
   input  wire logic [WIDTH-1:0] i_async,
   output logic      [WIDTH-1:0] o_sync
);
   logic [WIDTH-1:0] meta;
   logic [WIDTH-1:0] next_meta;
   logic [WIDTH-1:0] next_sync;

   always_comb
   begin
      next_meta = i_ce ? i_async : meta;
      next_sync = i_ce ? meta : o_sync;
   end

   // idle bus lines are high, so the stages reset high
   always_ff @(posedge i_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         meta   <= '1;
         o_sync <= '1;
      end
      else
      begin
         meta   <= next_meta;
         o_sync <= next_sync;
      end
   end
endmodule

// file: ssc_core_properties.sv
// assertion checker for the serial status and control block
`timescale 1ns/1ps
module ssc_core_properties (
   // clock, reset and register port
   input wire logic       i_clk,
   input wire logic       i_rst_b,
   input wire logic       i_ce,
   input wire logic [1:0] i_addr,
   input wire logic [7:0] i_wdata,
   input wire logic       i_wr,
   input wire logic       i_rd,
   input wire logic [7:0] o_rdata,
   // interrupt side
   input wire logic       i_global_ie,
   input wire logic       o_irq_start,
   input wire logic       o_irq_wrap,
   input wire logic       o_wake_idle,
   // port bits and pins
   input wire logic       i_port_sda,
   input wire logic       i_ddr_sda,
   input wire logic       i_port_scl,
   input wire logic       i_ddr_scl,
   input wire logic       o_do_override,
   input wire logic       o_two_wire,
   input wire logic       o_pullup_dis,
   input wire logic       o_sda_out,
   input wire logic       o_sda_oe,
   input wire logic       o_scl_out,
   input wire logic       o_scl_oe
);
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (!i_rst_b);
   wake_follow_a: assert property (o_wake_idle == (o_irq_start | o_irq_wrap))
      else $error("idle wake does not follow the requests");
   wrap_gate_a: assert property (o_irq_wrap |-> i_global_ie)
      else $error("wrap request without global enable");
   start_gate_a: assert property (o_irq_start |-> i_global_ie)
      else $error("start request without global enable");
   line_open_a: assert property (!o_sda_out && !o_scl_out)
      else $error("bus line driven high");
   off_quiet_a: assert property (!o_two_wire |-> !o_sda_oe && !o_scl_oe)
      else $error("bus driver active outside two-wire mode");
   sda_pull_a: assert property (o_two_wire && i_ddr_sda && !i_port_sda |-> o_sda_oe)
      else $error("data line not pulled low");
   scl_pull_a: assert property (o_two_wire && i_ddr_scl && !i_port_scl |-> o_scl_oe)
      else $error("clock line not pulled low");
   driver_dir_a: assert property ((!o_sda_oe || i_ddr_sda) && (!o_scl_oe || i_ddr_scl))
      else $error("driver active with direction bit clear");
   pullup_off_a: assert property (o_pullup_dis == o_two_wire)
      else $error("pull-up disable differs from two-wire mode");
   mode_write_a: assert property (i_ce && i_wr && i_addr == 2'h1 |=> o_two_wire == $past(i_wdata[5])
      && o_do_override == ($past(i_wdata[5:4]) == 2'h1))
      else $error("wire mode outputs do not follow control write");
   unmapped_rd_a: assert property (i_ce && i_rd && i_addr == 2'h3 |=> o_rdata == 8'h00)
      else $error("unmapped read not zero");
endmodule

bind ssc_core ssc_core_properties chk_u (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_ce(i_ce), .i_addr(i_addr),
   .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_global_ie(i_global_ie),
   .o_irq_start(o_irq_start), .o_irq_wrap(o_irq_wrap), .o_wake_idle(o_wake_idle), .i_port_sda(i_port_sda),
   .i_ddr_sda(i_ddr_sda), .i_port_scl(i_port_scl), .i_ddr_scl(i_ddr_scl), .o_do_override(o_do_override),
   .o_two_wire(o_two_wire), .o_pullup_dis(o_pullup_dis), .o_sda_out(o_sda_out), .o_sda_oe(o_sda_oe),
   .o_scl_out(o_scl_out), .o_scl_oe(o_scl_oe));

// file: ssc_bus_master.sv
// far-side bus master model for the two open-collector lines
`timescale 1ns/1ps
module ssc_bus_master (
   // pull requests from the block
   input  wire logic i_sda_oe,
   input  wire logic i_scl_oe,
   // line levels seen by everyone
   output logic      o_sda,
   output logic      o_scl
);
   logic sda_rel = 1'b1;
   logic scl_rel = 1'b1;
   // pull-ups win only while nobody pulls low
   assign o_sda = sda_rel & ~i_sda_oe;
   assign o_scl = scl_rel & ~i_scl_oe;
   // one half of the 160 ns link clock per step; clock stands still between steps
   task automatic drive(input logic sda, input logic scl);
      sda_rel <= sda;
      scl_rel <= scl;
      #80;
   endtask
endmodule

// file: tb.sv
// self-checking bench for the serial status and control block
`timescale 1ns/1ps
module tb;
   logic       clk = 0;
   logic       rst_b = 0;
   logic [1:0] addr = 0;
   logic [7:0] wdata = 0;
   logic       wr = 0;
   logic       rd = 0;
   logic       gie = 0;
   logic       tov = 0;
   logic       psda = 1;
   logic       dsda = 0;
   logic       pscl = 1;
   logic       dscl = 0;
   logic [7:0] rdata;
   logic       ce = 1;
   logic       ddo = 1;
   logic       irq_s, irq_w, wake_i, twire, ovr, sda_oe, scl_oe, sda_ln, scl_ln;
   logic       wake_a, tgl, do_out, do_oe, do_pu;
   int         n_mismatch = 0;
   int         samples_checked = 0;
   // {control, port_sda, ddr_sda, port_scl, ddr_scl, two_wire, override, sda_oe, scl_oe}
   logic [15:0] rows [7] = '{16'h0050, 16'h1054, 16'h2099, 16'h205b, 16'h2008, 16'h30d9, 16'h00d0};

   always #10 clk = ~clk;

   ssc_core dut_u (.i_clk(clk), .i_rst_b(rst_b), .i_ce(ce), .i_addr(addr), .i_wdata(wdata), .i_wr(wr),
      .i_rd(rd), .o_rdata(rdata), .i_global_ie(gie), .i_timer0_ovf(tov), .o_irq_start(irq_s),
      .o_irq_wrap(irq_w), .o_wake_idle(wake_i), .o_wake_all(wake_a), .i_port_do(1'b1), .i_ddr_do(ddo),
      .i_port_sda(psda), .i_ddr_sda(dsda), .i_port_scl(pscl), .i_ddr_scl(dscl), .o_scl_toggle(tgl),
      .i_sda_pin(sda_ln), .i_scl_pin(scl_ln), .o_do_override(ovr), .o_do_out(do_out), .o_do_oe(do_oe),
      .o_do_pullup(do_pu), .o_two_wire(twire), .o_pullup_dis(), .o_sda_out(), .o_sda_oe(sda_oe),
      .o_scl_out(), .o_scl_oe(scl_oe));
   ssc_bus_master bus_u (.i_sda_oe(sda_oe), .i_scl_oe(scl_oe), .o_sda(sda_ln), .o_scl(scl_ln));

   task automatic wreg(input logic [1:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic wt(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      samples_checked++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // read strobe one cycle, data taken in the cycle after it
   task automatic chk_reg(input logic [1:0] a, input logic [7:0] m, input logic [7:0] exp);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      chk(rdata & m, exp);
   endtask
   task automatic done(input string s);
      $display("test %s finished, %0d mismatches so far", s, n_mismatch);
   endtask
   task automatic print_verdict();
      $display("%0d comparisons, %0d mismatches", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   initial
   begin
      #50us;
      n_mismatch++;
      print_verdict();
   end

   initial
   begin
      repeat (5) @(posedge clk);
      rst_b <= 1'b1;
      chk_reg(ssc_pkg::ADDR_STATUS, 8'hef, 8'h00);
      chk_reg(ssc_pkg::ADDR_CONTROL, 8'hff, 8'h00);
      wreg(2'h3, 8'h5a);
      chk_reg(2'h3, 8'hff, 8'h00);
      done("reset");
      wreg(ssc_pkg::ADDR_SHIFT, 8'h80);
      foreach (rows[i])
      begin
         @(posedge clk);
         {psda, dsda, pscl, dscl} <= rows[i][7:4];
         wreg(ssc_pkg::ADDR_CONTROL, rows[i][15:8]);
         wt(2);
         chk({4'h0, twire, ovr, sda_oe, scl_oe}, {4'h0, rows[i][3:0]});
      end
      wreg(ssc_pkg::ADDR_CONTROL, 8'h10);
      wt(1);
      chk({5'h0, do_out, do_oe, do_pu}, 8'h06);
      @(posedge clk);
      ddo <= 1'b0;
      wt(1);
      chk({5'h0, do_out, do_oe, do_pu}, 8'h05);
      // a write while the clock enable is low must leave the counter alone
      @(posedge clk);
      ce <= 1'b0;
      wreg(ssc_pkg::ADDR_STATUS, 8'h0f);
      ce <= 1'b1;
      chk_reg(ssc_pkg::ADDR_STATUS, 8'h0f, 8'h00);
      done("modes");
      wreg(ssc_pkg::ADDR_STATUS, 8'he9);
      chk_reg(ssc_pkg::ADDR_STATUS, 8'hef, 8'h09);
      wreg(ssc_pkg::ADDR_STATUS, 8'h0f);
      wreg(ssc_pkg::ADDR_CONTROL, 8'h02);
      chk_reg(ssc_pkg::ADDR_STATUS, 8'h4f, 8'h40);
      @(posedge clk);
      gie <= 1'b1;
      wreg(ssc_pkg::ADDR_CONTROL, 8'h40);
      wt(1);
      chk({5'h0, irq_w, wake_i, wake_a}, 8'h06);
      wreg(ssc_pkg::ADDR_STATUS, 8'h00);
      chk_reg(ssc_pkg::ADDR_STATUS, 8'h40, 8'h40);
      wreg(ssc_pkg::ADDR_STATUS, 8'h40);
      wt(1);
      chk({7'h0, irq_w}, 8'h00);
      done("wrap");
      wreg(ssc_pkg::ADDR_CONTROL, 8'h04);
      repeat (3)
      begin
         @(posedge clk);
         tov <= 1'b1;
         @(posedge clk);
         tov <= 1'b0;
      end
      chk_reg(ssc_pkg::ADDR_STATUS, 8'h0f, 8'h03);
      wreg(ssc_pkg::ADDR_CONTROL, 8'h08);
      bus_u.drive(1'b1, 1'b0);
      bus_u.drive(1'b1, 1'b1);
      wt(5);
      chk_reg(ssc_pkg::ADDR_STATUS, 8'h0f, 8'h05);
      wreg(ssc_pkg::ADDR_CONTROL, 8'h0a);
      wreg(ssc_pkg::ADDR_CONTROL, 8'h0b);
      wreg(ssc_pkg::ADDR_CONTROL, 8'h0b);
      #1;
      chk({7'h0, tgl}, 8'h01);
      chk_reg(ssc_pkg::ADDR_STATUS, 8'h0f, 8'h07);
      done("counting");
      wreg(ssc_pkg::ADDR_STATUS, 8'he0);
      @(posedge clk);
      {psda, dsda, pscl, dscl} <= 4'b1011;
      wreg(ssc_pkg::ADDR_CONTROL, 8'h28);
      bus_u.drive(1'b0, 1'b1);
      bus_u.drive(1'b0, 1'b0);
      wt(5);
      chk_reg(ssc_pkg::ADDR_STATUS, 8'h80, 8'h80);
      bus_u.drive(1'b0, 1'b1);
      chk({6'h0, scl_oe, scl_ln}, 8'h02);
      wreg(ssc_pkg::ADDR_CONTROL, 8'ha8);
      wt(1);
      chk({5'h0, irq_s, wake_i, wake_a}, 8'h07);
      wreg(ssc_pkg::ADDR_STATUS, 8'h80);
      wt(1);
      chk({7'h0, scl_oe}, 8'h00);
      wreg(ssc_pkg::ADDR_CONTROL, 8'ha8);
      bus_u.drive(1'b1, 1'b1);
      wt(5);
      chk_reg(ssc_pkg::ADDR_STATUS, 8'ha0, 8'h20);
      chk({7'h0, irq_s}, 8'h00);
      done("start and stop");
      wreg(ssc_pkg::ADDR_STATUS, 8'hef);
      // the strobe bit counts only when the stored source is already software
      wreg(ssc_pkg::ADDR_CONTROL, 8'h30);
      wreg(ssc_pkg::ADDR_CONTROL, 8'h32);
      wt(1);
      chk({7'h0, scl_oe}, 8'h01);
      wreg(ssc_pkg::ADDR_STATUS, 8'h40);
      wt(1);
      chk({7'h0, scl_oe}, 8'h00);
      wreg(ssc_pkg::ADDR_SHIFT, 8'h00);
      wt(3);
      chk_reg(ssc_pkg::ADDR_STATUS, 8'h10, 8'h10);
      done("hold and collision");
      print_verdict();
   end
endmodule
